// ==== core/arbc_cfg.svh ====
// Register offsets, reset values, backoff limit codes and result codes of the auto-retry/backoff config bank
//
// How it works
// R1: Frame retransmission count readable as a 4-bit field, 0 to 15.
// R2: Backoff retry count readable as a 3-bit field, 0 to 5.
// R3: Both live counters update when a backoff cycle or transmit cycle begins.
// R4: Retransmit unacknowledged frame at most the limit (default 3, legal 0..15), then cancel.
// R5: Repeat channel access at most the backoff limit (default 4, legal 0..5), then cancel.
// R6: Backoff limit 7 sends at once without channel access; 6 is reserved.
// R7: Slot-aligned bit 0 (default): acknowledgment sent automatically when requested.
// R8: Slot-aligned bit 1: acknowledgment not sent on its own; host controls it.
// R9: Host times slotted acknowledgments to start on backoff slot boundaries.
// R10: Host rising edge on trigger pin starts slotted acknowledgment; device sends then.
// R11: While awaiting the trigger, transaction result shows the ack-wait success code.
// R12: Seed low byte is read/write and resets to 0xea.
// R13: Seed is the low byte plus 3 high bits; it drives backoff randomness.
// R14: Every wakeup from deepest sleep reloads the backoff generator from the seed.
// R15: Host should load both seed fields with random values.
// R16: Host should rewrite the seed fields after every deepest sleep period.
// R17: Seed-high register holds version accept, pending, suppress, coordinator, seed high.
// R18: Live counter register is read-only; writes leave counters unchanged.
// R19: With acknowledge suppress set, no acknowledgment is ever transmitted; the code checks only new requests, so a held slotted ack is still sent.
// R20: Both live counters clear to zero at each new transaction start.
`ifndef ARBC_CFG_SVH
`define ARBC_CFG_SVH

`define ARBC_ADDR_W 6
`define ARBC_OFS_COUNTERS 6'h19
`define ARBC_OFS_LIMITS 6'h2c
`define ARBC_OFS_SEED_LO 6'h2d
`define ARBC_OFS_SEED_HI 6'h2e

`define ARBC_RST_LIMITS 8'h38
`define ARBC_RST_SEED_LO 8'hea
`define ARBC_RST_SEED_HI 8'h42

`define ARBC_BO_LIMIT_MAX 3'h5
`define ARBC_BO_LIMIT_RSVD 3'h6
`define ARBC_BO_LIMIT_NOCCA 3'h7

`define ARBC_TR_SUCCESS 3'h0
`define ARBC_TR_ACK_WAIT 3'h1
`define ARBC_TR_NO_ACK 3'h5
`define ARBC_TR_CH_BUSY 3'h3
`define ARBC_TR_IDLE 3'h7

`endif

// ==== core/arbc_pkg.sv ====
// Types for the auto-retry/backoff config bank
`default_nettype none
package arbc_pkg;

    typedef struct packed {
        logic [3:0] frame_retry_limit;
        logic [2:0] backoff_retry_limit;
        logic slotted_ack;
    } arbc_limits_t;

    typedef struct packed {
        logic [1:0] frame_version_accept;
        logic pending_flag_value;
        logic ack_suppress;
        logic coordinator_role;
        logic [2:0] seed_high;
    } arbc_seed_hi_t;

    typedef struct packed {
        logic [3:0] live_retx_count;
        logic [2:0] live_backoff_retry_count;
        logic reserved0;
    } arbc_counters_t;

    typedef enum logic [2:0] {
        ARBC_IDLE = 3'b000,
        ARBC_BACKOFF = 3'b001,
        ARBC_TX = 3'b010,
        ARBC_ACK_WAIT = 3'b011,
        ARBC_RX_ACK_HOLD = 3'b100,
        ARBC_ACK_TX = 3'b101
    } arbc_state_t;

endpackage

`default_nettype wire

// ==== core/arbc_top.sv ====
// Auto-retry transmit sequencer, slotted acknowledge control and seed registers
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "arbc_cfg.svh"

module arbc_top (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic [`ARBC_ADDR_W-1:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic TX_START_I,
    input wire logic CCA_IDLE_I,
    input wire logic CCA_DONE_I,
    input wire logic TX_DONE_I,
    input wire logic ACK_RX_I,
    input wire logic ACK_TIMEOUT_I,
    input wire logic RX_ACK_REQ_I,
    input wire logic DEEPEST_SLEEP_STATE_WAKE_I,
    input wire logic SLEEP_TX_TRIGGER_PIN_I,
    output logic FRAME_TX_O,
    output logic ACK_TX_O,
    output logic [2:0] TRANSACTION_RESULT_O,
    output logic TXN_DONE_O,
    output logic [10:0] BACKOFF_RANDOM_O,
    output logic [1:0] FRAME_VERSION_ACCEPT_O,
    output logic PENDING_FLAG_VALUE_O,
    output logic COORDINATOR_ROLE_O
);

    arbc_pkg::arbc_limits_t limits_r;
    arbc_pkg::arbc_seed_hi_t seed_hi_r;
    logic [7:0] seed_lo_r;
    logic [3:0] retx_r;
    logic [2:0] bo_retry_r;
    arbc_pkg::arbc_state_t state_r;
    logic [2:0] result_r;
    logic [10:0] lfsr_r;
    logic trig_s1_r;
    logic trig_s2_r;
    logic trig_s3_r;
    logic trig_rise;
    logic wr_limits;
    logic wr_seed_lo;
    logic wr_seed_hi;
    logic [7:0] rdata_nxt;
    arbc_pkg::arbc_counters_t counters;

    function automatic logic addr_hit(input logic [`ARBC_ADDR_W-1:0] a, input logic [`ARBC_ADDR_W-1:0] ofs);
        addr_hit = (a == ofs);
    endfunction

    assign wr_limits = WR_I && addr_hit(ADDR_I, `ARBC_OFS_LIMITS);
    assign wr_seed_lo = WR_I && addr_hit(ADDR_I, `ARBC_OFS_SEED_LO);
    assign wr_seed_hi = WR_I && addr_hit(ADDR_I, `ARBC_OFS_SEED_HI);

    // Writable control registers
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            limits_r <= `ARBC_RST_LIMITS;
        end else if (wr_limits) begin
            limits_r <= WDATA_I;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            seed_lo_r <= `ARBC_RST_SEED_LO; // see R12
        end else if (wr_seed_lo) begin
            seed_lo_r <= WDATA_I; // see R12
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            seed_hi_r <= `ARBC_RST_SEED_HI;
        end else if (wr_seed_hi) begin
            seed_hi_r <= WDATA_I; // see R17
        end
    end

    // Counter register has no write path
    assign counters = '{live_retx_count: retx_r, live_backoff_retry_count: bo_retry_r, reserved0: 1'b0}; // see R18

    always_comb begin
        rdata_nxt = 8'h00;
        if (addr_hit(ADDR_I, `ARBC_OFS_COUNTERS)) begin
            rdata_nxt = counters; // see R1 // see R2
        end else if (addr_hit(ADDR_I, `ARBC_OFS_LIMITS)) begin
            rdata_nxt = limits_r;
        end else if (addr_hit(ADDR_I, `ARBC_OFS_SEED_LO)) begin
            rdata_nxt = seed_lo_r;
        end else if (addr_hit(ADDR_I, `ARBC_OFS_SEED_HI)) begin
            rdata_nxt = seed_hi_r; // see R17
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            RDATA_O <= 8'h00;
        end else if (RD_I) begin
            RDATA_O <= rdata_nxt;
        end else begin
            RDATA_O <= 8'h00;
        end
    end

    // Trigger pin synchroniser and edge detect
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_s3_r <= 1'b0;
        end else begin
            trig_s1_r <= SLEEP_TX_TRIGGER_PIN_I;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;
        end
    end

    assign trig_rise = trig_s2_r && !trig_s3_r;

    // Backoff random generator, reloaded from the seed on wake
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            lfsr_r <= 11'({`ARBC_RST_SEED_HI, `ARBC_RST_SEED_LO});
        end else if (DEEPEST_SLEEP_STATE_WAKE_I) begin
            lfsr_r <= {seed_hi_r.seed_high, seed_lo_r}; // see R13 // see R14
        end else if (lfsr_r == 11'h000) begin
            lfsr_r <= 11'h001;
        end else begin
            lfsr_r <= {lfsr_r[9:0], lfsr_r[10] ^ lfsr_r[8]}; // see R13
        end
    end

    assign BACKOFF_RANDOM_O = lfsr_r;

    // Transaction sequencer and live counters
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            state_r <= arbc_pkg::ARBC_IDLE;
            retx_r <= 4'h0;
            bo_retry_r <= 3'h0;
            result_r <= `ARBC_TR_IDLE;
            TXN_DONE_O <= 1'b0;
        end else begin
            TXN_DONE_O <= 1'b0;
            unique case (state_r)
                arbc_pkg::ARBC_IDLE: begin
                    if (TX_START_I) begin
                        retx_r <= 4'h0; // see R20
                        bo_retry_r <= 3'h0; // see R20
                        if (limits_r.backoff_retry_limit == `ARBC_BO_LIMIT_NOCCA) begin
                            state_r <= arbc_pkg::ARBC_TX; // see R6
                        end else begin
                            state_r <= arbc_pkg::ARBC_BACKOFF;
                        end
                    end else if (RX_ACK_REQ_I && !seed_hi_r.ack_suppress) begin // see R19
                        if (limits_r.slotted_ack) begin
                            state_r <= arbc_pkg::ARBC_RX_ACK_HOLD; // see R8
                            result_r <= `ARBC_TR_ACK_WAIT; // see R11
                        end else begin
                            state_r <= arbc_pkg::ARBC_ACK_TX; // see R7
                        end
                    end
                end
                arbc_pkg::ARBC_BACKOFF: begin
                    if (CCA_DONE_I) begin
                        if (CCA_IDLE_I) begin
                            state_r <= arbc_pkg::ARBC_TX;
                        end else if (bo_retry_r >= limits_r.backoff_retry_limit
                                     || bo_retry_r >= `ARBC_BO_LIMIT_MAX) begin
                            state_r <= arbc_pkg::ARBC_IDLE; // see R5
                            result_r <= `ARBC_TR_CH_BUSY;
                            TXN_DONE_O <= 1'b1;
                        end else begin
                            bo_retry_r <= bo_retry_r + 3'h1; // see R3
                        end
                    end
                end
                arbc_pkg::ARBC_TX: begin
                    if (TX_DONE_I) begin
                        state_r <= arbc_pkg::ARBC_ACK_WAIT;
                    end
                end
                arbc_pkg::ARBC_ACK_WAIT: begin
                    if (ACK_RX_I) begin
                        state_r <= arbc_pkg::ARBC_IDLE;
                        result_r <= `ARBC_TR_SUCCESS;
                        TXN_DONE_O <= 1'b1;
                    end else if (ACK_TIMEOUT_I) begin
                        if (retx_r >= limits_r.frame_retry_limit) begin
                            state_r <= arbc_pkg::ARBC_IDLE; // see R4
                            result_r <= `ARBC_TR_NO_ACK;
                            TXN_DONE_O <= 1'b1;
                        end else begin
                            retx_r <= retx_r + 4'h1; // see R3
                            bo_retry_r <= 3'h0; // see R3
                            if (limits_r.backoff_retry_limit == `ARBC_BO_LIMIT_NOCCA) begin
                                state_r <= arbc_pkg::ARBC_TX;
                            end else begin
                                state_r <= arbc_pkg::ARBC_BACKOFF;
                            end
                        end
                    end
                end
                arbc_pkg::ARBC_RX_ACK_HOLD: begin
                    if (trig_rise) begin
                        state_r <= arbc_pkg::ARBC_ACK_TX; // see R10
                    end
                end
                arbc_pkg::ARBC_ACK_TX: begin
                    state_r <= arbc_pkg::ARBC_IDLE;
                    result_r <= `ARBC_TR_SUCCESS;
                end
                default: begin
                    state_r <= arbc_pkg::ARBC_IDLE;
                end
            endcase
        end
    end

    assign FRAME_TX_O = (state_r == arbc_pkg::ARBC_TX);
    assign ACK_TX_O = (state_r == arbc_pkg::ARBC_ACK_TX); // see R7 // see R10
    assign TRANSACTION_RESULT_O = result_r;
    assign FRAME_VERSION_ACCEPT_O = seed_hi_r.frame_version_accept;
    assign PENDING_FLAG_VALUE_O = seed_hi_r.pending_flag_value;
    assign COORDINATOR_ROLE_O = seed_hi_r.coordinator_role;

endmodule

`default_nettype wire

// ==== tb/arbc_host_model.sv ====
// Host model: register port master and trigger pin driver
`timescale 1ns/1ns
`default_nettype none
module arbc_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [5:0] addr_o = 6'h00,
    output logic [7:0] wdata_o = 8'h00,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0,
    output logic trig_o = 1'b0
);
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] v, output logic [7:0] q);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= v;
        wr_o <= w;
        rd_o <= !w;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        @(negedge clk_i);
        q = rdata_i;
    endtask
    // Edges land on a clock edge, standing in for a slot boundary
    task automatic trig(input logic v);
        @(posedge clk_i);
        trig_o <= v;
    endtask
endmodule
`default_nettype wire

// ==== tb/arbc_top_props.sv ====
// Port-level assertions for the retry/backoff register bank
`timescale 1ns/1ns
`default_nettype none
`include "arbc_cfg.svh"
module arbc_top_props (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic [`ARBC_ADDR_W-1:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic TX_START_I,
    input wire logic RX_ACK_REQ_I,
    input wire logic DEEPEST_SLEEP_STATE_WAKE_I,
    input wire logic SLEEP_TX_TRIGGER_PIN_I,
    input wire logic FRAME_TX_O,
    input wire logic ACK_TX_O,
    input wire logic [2:0] TRANSACTION_RESULT_O,
    input wire logic TXN_DONE_O,
    input wire logic [10:0] BACKOFF_RANDOM_O
);
    logic [7:0] lim_r, lo_r, hi_r;
    logic busy_r;
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Shadow copies of host writes
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            lim_r <= `ARBC_RST_LIMITS;
            lo_r <= `ARBC_RST_SEED_LO;
            hi_r <= `ARBC_RST_SEED_HI;
        end else if (WR_I) begin
            if (ADDR_I == `ARBC_OFS_LIMITS) lim_r <= WDATA_I;
            if (ADDR_I == `ARBC_OFS_SEED_LO) lo_r <= WDATA_I;
            if (ADDR_I == `ARBC_OFS_SEED_HI) hi_r <= WDATA_I;
        end
    end
    always_ff @(posedge CORE_CLK_I) busy_r <= RST_N_I && !TXN_DONE_O && (busy_r || TX_START_I);
    sequence ack_req_s;
        RX_ACK_REQ_I && !busy_r && !hi_r[4];
    endsequence
    sequence trig_s;
        $rose(SLEEP_TX_TRIGGER_PIN_I) && TRANSACTION_RESULT_O == 3'h1;
    endsequence
    seed_low_a: assert property (RD_I && ADDR_I == `ARBC_OFS_SEED_LO |=> RDATA_O == lo_r)
        else $error("seed low readback wrong");
    counters_rng_a: assert property (RD_I && ADDR_I == `ARBC_OFS_COUNTERS |=> RDATA_O[3:1] <= 3'h5 && !RDATA_O[0])
        else $error("counter register out of range");
    wake_load_a: assert property (DEEPEST_SLEEP_STATE_WAKE_I |=> BACKOFF_RANDOM_O == {hi_r[2:0], lo_r})
        else $error("generator not reloaded");
    direct_tx_a: assert property (TX_START_I && !busy_r && lim_r[3:1] == 3'h7 |=> FRAME_TX_O)
        else $error("no direct transmit");
    ack_auto_a: assert property (ack_req_s ##0 !lim_r[0] |=> ACK_TX_O)
        else $error("ack not sent");
    ack_slot_a: assert property (ack_req_s ##0 lim_r[0] |=> !ACK_TX_O && TRANSACTION_RESULT_O == 3'h1)
        else $error("slotted ack wrong");
    ack_supp_a: assert property (RX_ACK_REQ_I && hi_r[4] |=> (!ACK_TX_O) [*4])
        else $error("suppressed ack sent");
    trig_ack_a: assert property (trig_s |-> ##[1:6] ACK_TX_O)
        else $error("trigger gave no ack");
endmodule
bind arbc_top arbc_top_props i_arbc_top_props (.*);
`default_nettype wire

// ==== tb/arbc_top_tb_top.sv ====
// Self-checking bench for the retry/backoff register bank
`timescale 1ns/1ns
`default_nettype none
module arbc_top_tb_top;
    // Pulses: 0 start, 1 cca done, 2 tx done, 3 ack rx, 4 ack timeout, 5 ack request, 6 wake
    logic [6:0] ev;
    logic clk, rst_n, cca_idle, wr, rd, trig, frame_tx, ack_tx, done, pend, coord;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [1:0] fva;
    logic [2:0] res;
    logic [10:0] rnd;
    int bad_count = 0;
    int check_count = 0;
    arbc_host_model i_arbc_host_model (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd), .trig_o(trig));
    arbc_top i_arbc_top (.CORE_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .TX_START_I(ev[0]), .CCA_IDLE_I(cca_idle), .CCA_DONE_I(ev[1]), .TX_DONE_I(ev[2]),
        .ACK_RX_I(ev[3]), .ACK_TIMEOUT_I(ev[4]), .RX_ACK_REQ_I(ev[5]), .DEEPEST_SLEEP_STATE_WAKE_I(ev[6]),
        .SLEEP_TX_TRIGGER_PIN_I(trig), .FRAME_TX_O(frame_tx), .ACK_TX_O(ack_tx), .TRANSACTION_RESULT_O(res),
        .TXN_DONE_O(done), .BACKOFF_RANDOM_O(rnd), .FRAME_VERSION_ACCEPT_O(fva), .PENDING_FLAG_VALUE_O(pend),
        .COORDINATOR_ROLE_O(coord));
    task automatic end_sim();
        if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic w(input logic [5:0] a, input logic [7:0] v);
        i_arbc_host_model.xfer(1'b1, a, v, d);
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        i_arbc_host_model.xfer(1'b0, a, 8'h00, d);
        chk("register", {3'h0, e}, {3'h0, d});
    endtask
    task automatic pulses(input int q[$]);
        foreach (q[i]) begin
            @(posedge clk);
            ev[q[i]] <= 1'b1;
            @(posedge clk);
            ev[q[i]] <= 1'b0;
        end
        // Settle past the last sampling edge before any check
        @(negedge clk);
    endtask
    task automatic wait_sig(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (s !== 1'b1) begin
            bad_count++;
            end_sim();
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        ev = 7'h00;
        cca_idle = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rchk(6'h2c, 8'h38);
        rchk(6'h2d, 8'hea);
        rchk(6'h2e, 8'h42);
        rchk(6'h3f, 8'h00);
        w(6'h19, 8'hff);
        rchk(6'h19, 8'h00);
        w(6'h2d, 8'h5c);
        w(6'h2e, 8'hed);
        rchk(6'h2e, 8'hed);
        chk("fields", 11'h00f, {7'h00, fva, pend, coord});
        pulses('{6});
        chk("seed", 11'h55c, rnd);
        w(6'h2c, 8'h04);
        pulses('{0, 1, 1});
        rchk(6'h19, 8'h04);
        pulses('{1});
        wait_sig(done);
        chk("result", 11'h003, {8'h00, res});
        w(6'h2c, 8'h14);
        cca_idle <= 1'b1;
        pulses('{0, 1, 2, 4});
        rchk(6'h19, 8'h10);
        pulses('{1, 2, 4});
        wait_sig(done);
        chk("result", 11'h005, {8'h00, res});
        pulses('{0});
        rchk(6'h19, 8'h00);
        pulses('{1, 2, 3});
        wait_sig(done);
        chk("result", 11'h000, {8'h00, res});
        w(6'h2c, 8'h0e);
        pulses('{0});
        chk("frame_tx", 11'h001, {10'h000, frame_tx});
        pulses('{2, 3});
        wait_sig(done);
        chk("result", 11'h000, {8'h00, res});
        pulses('{5});
        chk("ack", 11'h001, {10'h000, ack_tx});
        w(6'h2c, 8'h0f);
        pulses('{5});
        chk("ack", 11'h000, {10'h000, ack_tx});
        chk("result", 11'h001, {8'h00, res});
        i_arbc_host_model.trig(1'b1);
        wait_sig(ack_tx);
        i_arbc_host_model.trig(1'b0);
        w(6'h2c, 8'h0e);
        w(6'h2e, 8'hfd);
        pulses('{5});
        repeat (4) begin
            chk("ack", 11'h000, {10'h000, ack_tx});
            @(negedge clk);
        end
        end_sim();
    end
endmodule
`default_nettype wire
